/* inc/hs_seq_pkg.sv */
`default_nettype none
package hs_seq_pkg;
  // current limit reference choices, in millivolts at the selector output
  localparam logic [11:0] SS_CLAMP_MV = 12'h064;     // 100 mV before the switch is enabled
  localparam logic [11:0] FOLD_CLAMP_MV = 12'h0C8;   // 200 mV floor under foldback
  // shunt figures in microvolts, kept for reference; the bench does not read them
  localparam int SHUNT_PRE_ON_UV = 2000;
  localparam int FOLD_FLOOR_UV = 4000;
  localparam int BREAKER_OFFSET_UV = 880;
  // soft-start and timing source figures in microamps
  localparam int SS_SOURCE_UA = 10;
  localparam int TIMING_UP_SLOW_UA = 3;
  localparam int TIMING_UP_FAST_UA = 60;
  localparam int TIMING_DN_SLOW_UA = 2;
  localparam int TIMING_DN_FAST_UA = 100;
  // timing node thresholds in millivolts
  localparam int TIMING_LOW_MV = 200;
  localparam int TIMING_HIGH_MV = 1000;
  // input synchroniser depth
  localparam int SYNC_STAGES = 2;

  // timing node source selection (at most one output pin on, none for SRC_NONE)
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_UP3,
    SRC_UP60,
    SRC_DN2,
    SRC_DN100,
    SRC_GROUND
  } timing_src_t;

  // reference selector choice
  typedef enum logic [1:0] {
    REF_PRE_ON,
    REF_SOFT,
    REF_SETPOINT,
    REF_FOLDBACK
  } ref_sel_t;

  typedef enum logic [3:0] {
    ST_RESET_HOLD,
    ST_INIT_CHARGE,
    ST_INIT_DISCHARGE,
    ST_OFF,
    ST_WAIT_TRIP,
    ST_ON,
    ST_LIMIT,
    ST_LATCHED,
    ST_LATCH_WAIT,
    ST_RETRY
  } seq_state_t;
endpackage
`default_nettype wire

/* hdl/pin_sync.sv */
`default_nettype none
// two-flop synchroniser for a bundle of asynchronous comparator levels
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;
endmodule // pin_sync
`default_nettype wire

/* hdl/hot_swap_timing_sequencer.sv */
`default_nettype none
// Notes on behaviour
// - before switch enable, reference is clamped at 100 mV (about 2 mV shunt)
// - after on request, soft-start node stays grounded until shunt reaches trip level
// - trip level sits 0.88 mV below the shunt limit; comparator handles offset
// - at trip during startup, 10 uA source ramps soft-start; reference follows
// - reference is lowest of setpoint, soft-start and foldback
// - foldback reference never drops below 200 mV (4 mV shunt)
// - timing node: 0.2 V and 1 V thresholds, 3/60 uA up, 2/100 uA down
// - during lockout reset, switch drive and timing node held low
// - initial cycle: 3 uA up to 1.0 V, then 100 uA down to 0.2 V
// - power-up starts after initial cycle only when supply window is good
// - at trip level, 60 uA pull-up on and drive regulates at the limit
// - shunt falls below trip before high threshold: 60 uA off, 2 uA down on
// - timing node reaching high threshold shuts drive and asserts fault-hold low
// - latch-off: 2 uA down, fault-hold stays low, no turn-on while discharging
// - after latch-off and low threshold, re-enable needs undervoltage or on toggle
// - autoretry: discharge at 2 uA, restart power-up at 0.2 V
// - retries repeat endlessly; board stops them by holding input low
// - supply good only when undervoltage above and overvoltage below 1 V
// - enable input must also be high before a power-up begins
module hot_swap_timing_sequencer
  import hs_seq_pkg::*;
#(
  parameter bit AUTORETRY = 1'b0
) (
  // clock and supply lockout reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // analog comparator results, asynchronous
  input wire logic UNDERVOLTAGE_INPUT,
  input wire logic OVERVOLTAGE_INPUT,
  input wire logic ENABLE_INPUT,
  input wire logic TIMING_HIGH_THRESHOLD,
  input wire logic TIMING_LOW_THRESHOLD,
  input wire logic BREAKER_TRIP_LEVEL,
  input wire logic SS_BELOW_SETPOINT,
  input wire logic SS_BELOW_FOLDBACK,
  input wire logic FOLDBACK_BELOW_SETPOINT,
  input wire logic FOLDBACK_BELOW_CLAMP,
  // software on bit, asynchronous level
  input wire logic ON_REQUEST,
  // pass switch drive
  output logic GATE_ENABLE,
  output logic GATE_PULLDOWN,
  output logic GATE_REGULATE,
  // soft-start node
  output logic SS_GROUND,
  output logic SS_SOURCE_EN,
  // current limit reference selector
  output logic [1:0] REF_SELECT,
  output logic REF_FOLD_CLAMP,
  // timing node sources
  output logic TIMING_UP3,
  output logic TIMING_UP60,
  output logic TIMING_DN2,
  output logic TIMING_DN100,
  output logic TIMING_GROUND,
  // fault-hold, open-drain, active low
  output logic FAULT_HOLD_N_OUT,
  output logic FAULT_HOLD_N_OE,
  // state observation
  output logic [3:0] SEQ_STATE
);

  localparam int NSYNC = 11;

  typedef struct packed {
    seq_state_t state;
    timing_src_t tsrc;
    ref_sel_t rsel;
    logic fold_clamp;
    logic gate_en;
    logic gate_pd;
    logic gate_reg;
    logic ss_gnd;
    logic ss_src;
    logic fault_low;
    logic uv_prev;
    logic on_prev;
    logic rearm_uv_low;
    logic rearm_off;
  } seq_t;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  logic uv_ok, ov_ok, en_ok, t_high, t_low, trip;
  logic ss_lt_set, ss_lt_fb, fb_lt_set, fb_lt_clamp, on_req;
  logic window_ok;
  seq_t st_reg;
  seq_t st_next;

  // comparator outputs cross in through two flops
  assign raw_in = {ON_REQUEST, FOLDBACK_BELOW_CLAMP, FOLDBACK_BELOW_SETPOINT,
                   SS_BELOW_FOLDBACK, SS_BELOW_SETPOINT, BREAKER_TRIP_LEVEL,
                   TIMING_LOW_THRESHOLD, TIMING_HIGH_THRESHOLD, ENABLE_INPUT,
                   OVERVOLTAGE_INPUT, UNDERVOLTAGE_INPUT};

  pin_sync #(.WIDTH(NSYNC)) u_sync (
    .clk(SYS_CLK),
    .reset_n(RESET_N),
    .async_in(raw_in),
    .sync_out(syn)
  );

  assign uv_ok = syn[0];
  assign ov_ok = ~syn[1];
  assign en_ok = syn[2];
  assign t_high = syn[3];
  assign t_low = syn[4];
  assign trip = syn[5];
  assign ss_lt_set = syn[6];
  assign ss_lt_fb = syn[7];
  assign fb_lt_set = syn[8];
  assign fb_lt_clamp = syn[9];
  assign on_req = syn[10];

  // supply window plus hardware enable
  assign window_ok = uv_ok & ov_ok & en_ok;

  // next-state logic for the whole sequencer
  always_comb begin
    st_next = st_reg;
    st_next.uv_prev = uv_ok;
    st_next.on_prev = on_req;
    st_next.gate_en = 1'b0;
    st_next.gate_pd = 1'b1;
    st_next.gate_reg = 1'b0;
    st_next.ss_gnd = 1'b1;
    st_next.ss_src = 1'b0;
    st_next.rsel = REF_PRE_ON;
    st_next.fold_clamp = 1'b0;
    st_next.tsrc = SRC_NONE;

    unique case (st_reg.state)
      ST_RESET_HOLD: begin
        // first edge after lockout release begins the initial cycle
        st_next.tsrc = SRC_UP3;
        st_next.state = ST_INIT_CHARGE;
      end
      ST_INIT_CHARGE: begin
        st_next.tsrc = SRC_UP3;
        if (t_high) begin
          st_next.tsrc = SRC_DN100;
          st_next.state = ST_INIT_DISCHARGE;
        end
      end
      ST_INIT_DISCHARGE: begin
        st_next.tsrc = SRC_DN100;
        if (!t_low) begin
          st_next.tsrc = SRC_NONE;
          st_next.state = ST_OFF;
        end
      end
      ST_OFF: begin
        // wait for a good window and the on bit
        if (window_ok && on_req) begin
          st_next.state = ST_WAIT_TRIP;
          st_next.gate_en = 1'b1;
          st_next.gate_pd = 1'b0;
        end
      end
      ST_WAIT_TRIP: begin
        st_next.gate_en = 1'b1;
        st_next.gate_pd = 1'b0;
        st_next.ss_gnd = 1'b1;
        st_next.tsrc = st_reg.tsrc == SRC_UP60 ? SRC_DN2 : SRC_NONE;
        if (trip) begin
          st_next.ss_gnd = 1'b0;
          st_next.ss_src = 1'b1;
          st_next.tsrc = SRC_UP60;
          st_next.gate_reg = 1'b1;
          st_next.state = ST_LIMIT;
        end
      end
      ST_ON, ST_LIMIT: begin
        st_next.gate_en = 1'b1;
        st_next.gate_pd = 1'b0;
        st_next.ss_gnd = 1'b0;
        st_next.ss_src = 1'b1;
        st_next.gate_reg = trip;
        st_next.tsrc = trip ? SRC_UP60 : SRC_DN2;
        st_next.state = trip ? ST_LIMIT : ST_ON;
        if (t_high && st_reg.tsrc == SRC_UP60) begin
          // sustained overcurrent: drive off, fault-hold low together
          st_next.gate_en = 1'b0;
          st_next.gate_pd = 1'b1;
          st_next.gate_reg = 1'b0;
          st_next.ss_gnd = 1'b1;
          st_next.ss_src = 1'b0;
          st_next.fault_low = 1'b1;
          st_next.tsrc = SRC_DN2;
          st_next.state = AUTORETRY ? ST_RETRY : ST_LATCHED;
        end
      end
      ST_LATCHED: begin
        // node discharging; turn-on refused
        st_next.tsrc = SRC_DN2;
        st_next.fault_low = 1'b1;
        if (!t_low) begin
          st_next.tsrc = SRC_NONE;
          st_next.rearm_uv_low = 1'b0;
          st_next.rearm_off = 1'b0;
          st_next.state = ST_LATCH_WAIT;
        end
      end
      ST_LATCH_WAIT: begin
        // re-arm on undervoltage low then high, or on bit off then on
        st_next.fault_low = 1'b1;
        if (!uv_ok) begin
          st_next.rearm_uv_low = 1'b1;
        end
        if (!on_req) begin
          st_next.rearm_off = 1'b1;
        end
        if ((st_reg.rearm_uv_low && uv_ok && !st_reg.uv_prev) ||
            (st_reg.rearm_off && on_req && !st_reg.on_prev)) begin
          st_next.fault_low = 1'b0;
          st_next.state = ST_OFF;
        end
      end
      ST_RETRY: begin
        // endless retry; board gates it through the undervoltage pin
        st_next.tsrc = SRC_DN2;
        st_next.fault_low = 1'b1;
        if (!t_low) begin
          st_next.tsrc = SRC_NONE;
          st_next.fault_low = 1'b0;
          st_next.state = ST_OFF;
        end
      end
      default: begin
        st_next.state = ST_OFF;
      end
    endcase

    // reference selector: lowest input wins, with floor under foldback
    if (st_next.gate_en && !st_next.ss_gnd) begin
      if (ss_lt_set && ss_lt_fb) begin
        st_next.rsel = REF_SOFT;
      end else if (fb_lt_set && !ss_lt_fb) begin
        st_next.rsel = REF_FOLDBACK;
        st_next.fold_clamp = fb_lt_clamp;
      end else begin
        st_next.rsel = REF_SETPOINT;
      end
    end

    // window loss: drive off in any powered phase, latched fault held
    if (!window_ok && (st_reg.state == ST_WAIT_TRIP || st_reg.state == ST_ON ||
        st_reg.state == ST_LIMIT)) begin
      st_next.state = ST_OFF;
      st_next.gate_en = 1'b0;
      st_next.gate_pd = 1'b1;
      st_next.gate_reg = 1'b0;
      st_next.ss_gnd = 1'b1;
      st_next.ss_src = 1'b0;
      st_next.rsel = REF_PRE_ON;
      st_next.fold_clamp = 1'b0;
      st_next.tsrc = SRC_NONE;
    end
  end

  // single state register; lockout holds drive and timing node low
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg <= '{state: ST_RESET_HOLD, tsrc: SRC_GROUND, rsel: REF_PRE_ON,
                  fold_clamp: 1'b0, gate_en: 1'b0, gate_pd: 1'b1, gate_reg: 1'b0,
                  ss_gnd: 1'b1, ss_src: 1'b0, fault_low: 1'b0, uv_prev: 1'b0,
                  on_prev: 1'b0, rearm_uv_low: 1'b0, rearm_off: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign GATE_ENABLE = st_reg.gate_en;
  assign GATE_PULLDOWN = st_reg.gate_pd;
  assign GATE_REGULATE = st_reg.gate_reg;
  assign SS_GROUND = st_reg.ss_gnd;
  assign SS_SOURCE_EN = st_reg.ss_src;
  assign REF_SELECT = st_reg.rsel;
  assign REF_FOLD_CLAMP = st_reg.fold_clamp;
  assign TIMING_UP3 = (st_reg.tsrc == SRC_UP3);
  assign TIMING_UP60 = (st_reg.tsrc == SRC_UP60);
  assign TIMING_DN2 = (st_reg.tsrc == SRC_DN2);
  assign TIMING_DN100 = (st_reg.tsrc == SRC_DN100);
  assign TIMING_GROUND = (st_reg.tsrc == SRC_GROUND);
  // open drain: only ever pulls low, board supplies the pull-up
  assign FAULT_HOLD_N_OUT = 1'b0;
  assign FAULT_HOLD_N_OE = st_reg.fault_low;
  assign SEQ_STATE = st_reg.state;

endmodule // hot_swap_timing_sequencer
`default_nettype wire

/* sim/hs_seq_sva.sv */
`default_nettype none
module hs_seq_sva (
  // clock and lockout
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // supply window and trip inputs
  input wire logic UNDERVOLTAGE_INPUT,
  input wire logic OVERVOLTAGE_INPUT,
  input wire logic ENABLE_INPUT,
  input wire logic TIMING_HIGH_THRESHOLD,
  input wire logic BREAKER_TRIP_LEVEL,
  // reference selector comparators
  input wire logic SS_BELOW_SETPOINT,
  input wire logic SS_BELOW_FOLDBACK,
  input wire logic FOLDBACK_BELOW_CLAMP,
  // drive, soft start and reference
  input wire logic GATE_ENABLE,
  input wire logic GATE_PULLDOWN,
  input wire logic GATE_REGULATE,
  input wire logic SS_GROUND,
  input wire logic SS_SOURCE_EN,
  input wire logic [1:0] REF_SELECT,
  input wire logic REF_FOLD_CLAMP,
  // timing sources and fault-hold
  input wire logic TIMING_UP3,
  input wire logic TIMING_UP60,
  input wire logic TIMING_DN2,
  input wire logic TIMING_DN100,
  input wire logic TIMING_GROUND,
  input wire logic FAULT_HOLD_N_OE,
  input wire logic [3:0] SEQ_STATE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // inputs reach the state after the two-flop sync, so answers get four edges
  sequence s_faulted;
    !GATE_ENABLE && FAULT_HOLD_N_OE && TIMING_DN2;
  endsequence
  sequence s_regulating;
    SS_SOURCE_EN && TIMING_UP60 && GATE_REGULATE;
  endsequence
  a_lockout_hold: assert property ($rose(RESET_N) |-> GATE_PULLDOWN && TIMING_GROUND && !GATE_ENABLE)
    else $error("drive or timing node not held low in lockout");
  a_init_charge: assert property ($rose(RESET_N) |=> TIMING_UP3)
    else $error("initial charge not started");
  a_init_discharge: assert property (TIMING_UP3 && $rose(TIMING_HIGH_THRESHOLD) |-> ##[1:4] TIMING_DN100)
    else $error("initial discharge not started");
  a_off_clamped: assert property (SEQ_STATE == 4'h3 |-> REF_SELECT == 2'h0 && SS_GROUND && GATE_PULLDOWN)
    else $error("reference not clamped while off");
  a_wait_grounded: assert property (SEQ_STATE == 4'h4 |-> SS_GROUND && !SS_SOURCE_EN)
    else $error("soft start released before trip");
  a_trip_ramp: assert property (SEQ_STATE == 4'h4 && $rose(BREAKER_TRIP_LEVEL) |-> ##[1:4] s_regulating)
    else $error("trip did not start ramp and timer");
  a_trip_release: assert property (TIMING_UP60 && $fell(BREAKER_TRIP_LEVEL) &&
    !TIMING_HIGH_THRESHOLD |-> ##[1:4] (TIMING_DN2 && !TIMING_UP60))
    else $error("timer not turned to slow discharge");
  a_fault_stop: assert property (TIMING_UP60 && $rose(TIMING_HIGH_THRESHOLD) |-> ##[1:4] s_faulted)
    else $error("fault did not shut drive");
  a_latched_off: assert property (SEQ_STATE == 4'h7 |-> s_faulted)
    else $error("latched state not holding off");
  a_enable_window: assert property ($rose(GATE_ENABLE) |->
    $past(UNDERVOLTAGE_INPUT, 3) && !$past(OVERVOLTAGE_INPUT, 3) && $past(ENABLE_INPUT, 3))
    else $error("drive enabled outside supply window");
  a_window_loss: assert property (GATE_ENABLE && $fell(UNDERVOLTAGE_INPUT)
    |-> ##[1:4] (!GATE_ENABLE && GATE_PULLDOWN))
    else $error("window loss did not pull drive down");
  a_sources_onehot: assert property ($onehot0({TIMING_UP3, TIMING_UP60, TIMING_DN2,
    TIMING_DN100, TIMING_GROUND}))
    else $error("more than one timing source on");
  // selector output lags its comparators by the sync plus the state register
  a_ref_soft: assert property (REF_SELECT == 2'h1 |->
    $past(SS_BELOW_SETPOINT, 3) && $past(SS_BELOW_FOLDBACK, 3))
    else $error("soft start chosen while not lowest");
  a_fold_floor: assert property (REF_FOLD_CLAMP |->
    REF_SELECT == 2'h3 && $past(FOLDBACK_BELOW_CLAMP, 3))
    else $error("foldback floor active outside foldback");
endmodule // hs_seq_sva
bind hot_swap_timing_sequencer hs_seq_sva hs_seq_sva_inst (.*);
`default_nettype wire

/* sim/hs_far_side.sv */
`default_nettype none
module hs_far_side (
  // clock
  input wire logic clk,
  // timing sources from the sequencer
  input wire logic up3,
  input wire logic up60,
  input wire logic dn2,
  input wire logic dn100,
  input wire logic gnd,
  // switch drive and bench load
  input wire logic gate_en,
  input wire logic overload,
  // comparator results
  output logic thr_high,
  output logic thr_low,
  output logic trip
);
  timeunit 1ns;
  timeprecision 1ns;
  int node_mv = 0;
  // capacitor integrates one millivolt per microamp each cycle; negedge keeps clear of sampling
  always @(negedge clk) begin
    int nxt;
    nxt = node_mv + (up3 ? 3 : 0) + (up60 ? 60 : 0) - (dn2 ? 2 : 0) - (dn100 ? 100 : 0);
    node_mv <= gnd ? 0 : (nxt < 0 ? 0 : nxt);
  end
  // thresholds at 1 V and 0.2 V
  assign thr_high = node_mv >= 1000;
  assign thr_low = node_mv >= 200;
  // shunt only carries load while the switch conducts
  assign trip = gate_en && overload;
endmodule // hs_far_side
`default_nettype wire

/* sim/hot_swap_timing_sequencer_tb_top.sv */
`default_nettype none
module hot_swap_timing_sequencer_tb_top
  import hs_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic uv; logic ov; logic en; logic on; logic gate;} row_t;
  typedef struct packed {logic ss_set; logic ss_fb; logic fb_set; logic fb_clamp;
    logic [1:0] sel; logic clamp;} ref_row_t;
  logic sys_clk = 0, reset_n = 0, uv = 1, ov = 0, en = 1, on = 0, overload = 0;
  logic ss_set = 0, ss_fb = 0, fb_set = 0, fb_clamp = 0, uv_hold = 1, overload_r = 0;
  logic ge, gpd, greg, ssg, sse, up3, up60, dn2, dn100, tgnd, fh_oe, thr_h, thr_l, trip;
  logic fclamp, fh_out, uv_tied;
  logic ge_r, up3_r, up60_r, dn2_r, dn100_r, tgnd_r, fh_oe_r, thr_h_r, thr_l_r, trip_r;
  logic [1:0] refsel;
  logic [3:0] state, state_r;
  int error_cnt = 0, compares = 0;
  row_t rows[8] = '{5'b00110, 5'b11110, 5'b10010, 5'b10100, 5'b10111, 5'b00110, 5'b10111,
    5'b11110};
  // selector cases: lowest of setpoint, soft start and foldback wins
  ref_row_t refs[5] = '{'{1'b1, 1'b1, 1'b0, 1'b0, REF_SOFT, 1'b0},
    '{1'b0, 1'b0, 1'b1, 1'b1, REF_FOLDBACK, 1'b1},
    '{1'b1, 1'b0, 1'b1, 1'b0, REF_FOLDBACK, 1'b0},
    '{1'b0, 1'b1, 1'b0, 1'b0, REF_SETPOINT, 1'b0},
    '{1'b0, 1'b0, 1'b0, 1'b0, REF_SETPOINT, 1'b0}};
  always #25 sys_clk = ~sys_clk;
  hot_swap_timing_sequencer #(.AUTORETRY(1'b0)) hot_swap_timing_sequencer_inst (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .UNDERVOLTAGE_INPUT(uv), .OVERVOLTAGE_INPUT(ov),
    .ENABLE_INPUT(en), .TIMING_HIGH_THRESHOLD(thr_h), .TIMING_LOW_THRESHOLD(thr_l),
    .BREAKER_TRIP_LEVEL(trip), .SS_BELOW_SETPOINT(ss_set), .SS_BELOW_FOLDBACK(ss_fb),
    .FOLDBACK_BELOW_SETPOINT(fb_set), .FOLDBACK_BELOW_CLAMP(fb_clamp), .ON_REQUEST(on),
    .GATE_ENABLE(ge), .GATE_PULLDOWN(gpd), .GATE_REGULATE(greg), .SS_GROUND(ssg),
    .SS_SOURCE_EN(sse), .REF_SELECT(refsel), .REF_FOLD_CLAMP(fclamp), .TIMING_UP3(up3),
    .TIMING_UP60(up60), .TIMING_DN2(dn2), .TIMING_DN100(dn100), .TIMING_GROUND(tgnd),
    .FAULT_HOLD_N_OUT(fh_out), .FAULT_HOLD_N_OE(fh_oe), .SEQ_STATE(state));
  hs_far_side hs_far_side_inst (.clk(sys_clk), .up3(up3), .up60(up60), .dn2(dn2),
    .dn100(dn100), .gnd(tgnd), .gate_en(ge), .overload(overload), .thr_high(thr_h),
    .thr_low(thr_l), .trip(trip));
  // autoretry board: fault-hold pulled up and tied to undervoltage, which it can hold low
  assign uv_tied = !fh_oe_r && uv_hold;
  hot_swap_timing_sequencer #(.AUTORETRY(1'b1)) hot_swap_timing_sequencer_retry_inst (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .UNDERVOLTAGE_INPUT(uv_tied),
    .OVERVOLTAGE_INPUT(1'b0), .ENABLE_INPUT(1'b1), .TIMING_HIGH_THRESHOLD(thr_h_r),
    .TIMING_LOW_THRESHOLD(thr_l_r), .BREAKER_TRIP_LEVEL(trip_r), .SS_BELOW_SETPOINT(1'b0),
    .SS_BELOW_FOLDBACK(1'b0), .FOLDBACK_BELOW_SETPOINT(1'b0), .FOLDBACK_BELOW_CLAMP(1'b0),
    .ON_REQUEST(1'b1), .GATE_ENABLE(ge_r), .GATE_PULLDOWN(), .GATE_REGULATE(),
    .SS_GROUND(), .SS_SOURCE_EN(), .REF_SELECT(), .REF_FOLD_CLAMP(), .TIMING_UP3(up3_r),
    .TIMING_UP60(up60_r), .TIMING_DN2(dn2_r), .TIMING_DN100(dn100_r),
    .TIMING_GROUND(tgnd_r), .FAULT_HOLD_N_OUT(), .FAULT_HOLD_N_OE(fh_oe_r),
    .SEQ_STATE(state_r));
  hs_far_side hs_far_side_retry_inst (.clk(sys_clk), .up3(up3_r), .up60(up60_r),
    .dn2(dn2_r), .dn100(dn100_r), .gnd(tgnd_r), .gate_en(ge_r), .overload(overload_r),
    .thr_high(thr_h_r), .thr_low(thr_l_r), .trip(trip_r));
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task chk(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task test_done;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // lockout, then the full initial timing cycle
  task do_reset;
    reset_n = 0;
    cyc(5);
    chk(gpd, 1'b1);
    chk(tgnd, 1'b1);
    chk(ge, 1'b0);
    reset_n = 1;
    cyc(2);
    chk(up3, 1'b1);
    for (int i = 0; i < 500 && thr_h !== 1'b1; i++) cyc(1);
    chk(thr_h, 1'b1);
    cyc(4);
    chk(dn100, 1'b1);
    for (int i = 0; i < 50 && state !== 4'h3; i++) cyc(1);
    chk(state === 4'h3, 1'b1);
  endtask
  // watchdog sized well above the roughly 2400 cycles of both sequences
  initial begin
    #1000000;
    error_cnt++;
    $display("BAD %0t: watchdog expired", $time);
    test_done;
  end
  initial begin
    do_reset;
    foreach (rows[i]) begin
      {uv, ov, en, on} = {rows[i].uv, rows[i].ov, rows[i].en, rows[i].on};
      cyc(8);
      chk(ge, rows[i].gate);
      chk(gpd, !rows[i].gate);
    end
    // power-up, brief trip, then sustained fault
    ov = 0;
    cyc(8);
    chk(ssg, 1'b1);
    overload = 1;
    for (int i = 0; i < 10 && up60 !== 1'b1; i++) cyc(1);
    chk(up60, 1'b1);
    chk(sse, 1'b1);
    chk(greg, 1'b1);
    overload = 0;
    cyc(5);
    chk(dn2, 1'b1);
    chk(up60, 1'b0);
    // reference selector while conducting below the trip level
    foreach (refs[i]) begin
      {ss_set, ss_fb, fb_set, fb_clamp} = {refs[i].ss_set, refs[i].ss_fb, refs[i].fb_set,
        refs[i].fb_clamp};
      cyc(4);
      chk(refsel === refs[i].sel, 1'b1);
      chk(fclamp, refs[i].clamp);
    end
    overload = 1;
    for (int i = 0; i < 100 && fh_oe !== 1'b1; i++) cyc(1);
    cyc(1);
    chk(ge, 1'b0);
    chk(fh_oe, 1'b1);
    chk(fh_out, 1'b0);
    chk(dn2, 1'b1);
    // on toggle while discharging is refused
    overload = 0;
    on = 0;
    cyc(4);
    on = 1;
    cyc(6);
    chk(ge, 1'b0);
    for (int i = 0; i < 1000 && thr_l !== 1'b0; i++) cyc(1);
    chk(thr_l, 1'b0);
    cyc(6);
    chk(ge, 1'b0);
    uv = 0;
    cyc(6);
    uv = 1;
    cyc(8);
    chk(ge, 1'b1);
    chk(fh_oe, 1'b0);
    // autoretry unit: fault, slow discharge, restart, fault again, then held off
    chk(state_r === ST_WAIT_TRIP, 1'b1);
    overload_r = 1;
    for (int i = 0; i < 100 && fh_oe_r !== 1'b1; i++) cyc(1);
    cyc(1);
    chk(ge_r, 1'b0);
    chk(state_r === ST_RETRY, 1'b1);
    chk(dn2_r, 1'b1);
    for (int i = 0; i < 1000 && ge_r !== 1'b1; i++) cyc(1);
    chk(ge_r, 1'b1);
    chk(fh_oe_r, 1'b0);
    for (int i = 0; i < 100 && fh_oe_r !== 1'b1; i++) cyc(1);
    chk(fh_oe_r, 1'b1);
    uv_hold = 0;
    for (int i = 0; i < 1000 && state_r !== ST_OFF; i++) cyc(1);
    cyc(20);
    chk(ge_r, 1'b0);
    chk(state_r === ST_OFF, 1'b1);
    // second lockout with the drive on
    do_reset;
    test_done;
  end
endmodule // hot_swap_timing_sequencer_tb_top
`default_nettype wire
